/* File: core/rcad_pkg.sv */
package rcad_pkg;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_FREQ_ADDR   = 8'h00; // clock_freq_control_reg
  localparam logic [7:0] DEV_MON_ADDR    = 8'h01; // monitor_port_pin function select
  localparam logic [7:0] DEV_CA_ADDR     = 8'h10; // base-clock counter, low byte first
  localparam logic [7:0] DEV_CB_ADDR     = 8'h14; // oscillator-clock counter, low byte first
  localparam logic [7:0] DEV_MODE_ADDR   = 8'h18; // converter_mode_reg
  localparam logic [7:0] DEV_CTRL_ADDR   = 8'h19; // converter_control_reg
  localparam logic [7:0] DEV_SBY_ADDR    = 8'h1a; // standby_control_reg

  // ----------------------------------------------------------------
  // device register values
  // ----------------------------------------------------------------
  localparam logic [7:0] FREQ_32K        = 8'h00;
  localparam logic [7:0] MODE_GATE_B     = 8'h10; // gating_select_bit set
  localparam logic [7:0] OM_REF_CH0      = 8'h01; // oscillate on reference_resistor_ch0
  localparam logic [7:0] OM_SENSOR_CH0   = 8'h02; // oscillate on sensor_resistor_ch0
  localparam logic [7:0] CTRL_RUN        = 8'h01; // conversion_run_bit
  localparam logic [7:0] SBY_HALT        = 8'h01; // halt_request_bit
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [24:0] CTR_SPAN       = 25'h1000000;
  localparam logic [3:0] P0_LAST_IDX     = 4'ha;
  localparam logic [3:0] P1_LAST_IDX     = 4'h5;
  localparam logic [1:0] CTR_LAST_BYTE   = 2'h2;
  localparam logic [1:0] DEV_RD_LAT      = 2'h1; // cycles from read strobe to data

  // ----------------------------------------------------------------
  // software register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [4:0] SW_CTRL_OFS     = 5'h00;
  localparam logic [4:0] SW_GATE_OFS     = 5'h04;
  localparam logic [4:0] SW_STAT_OFS     = 5'h08;
  localparam logic [4:0] SW_FIRST_OFS    = 5'h0c;
  localparam logic [4:0] SW_RESULT_OFS   = 5'h10;
  localparam int         CTRL_START_BIT  = 0;
  localparam int         CTRL_ORDER_BIT  = 1;
  localparam int         CTRL_MON_BIT    = 2;
  localparam int         STAT_BUSY_BIT   = 0;
  localparam int         STAT_DONE_BIT   = 1;
  localparam int         STAT_PHASE_BIT  = 2;
  localparam logic [23:0] GATE_RST       = 24'h0004b0;

  typedef enum logic [2:0] {
    RCAD_ST_IDLE  = 3'b000,
    RCAD_ST_WRITE = 3'b001,
    RCAD_ST_WAIT  = 3'b010,
    RCAD_ST_READ  = 3'b011
  } rcad_state_e;

  typedef enum logic [1:0] {
    RCAD_PS_IDLE  = 2'b00,
    RCAD_PS_DRIVE = 2'b01,
    RCAD_PS_LAT   = 2'b10
  } rcad_port_e;

endpackage

/* File: core/rcad_dev_port.sv */
`timescale 1ns/1ps
module rcad_dev_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // access request
  input  wire logic       req,
  input  wire logic       req_wr,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            ready,
  output logic            done_ff,
  output logic [7:0]      rdata_ff,
  // device register pins
  output logic [7:0]      dev_addr_ff,
  output logic [7:0]      dev_wdata_ff,
  output logic            dev_we_ff,
  output logic            dev_re_ff,
  input  wire logic [7:0] dev_rdata
);

  rcad_pkg::rcad_port_e state_ff;
  rcad_pkg::rcad_port_e nxt_state;
  logic [1:0]           lat_ff;
  logic [1:0]           nxt_lat;
  logic [7:0]           nxt_addr;
  logic [7:0]           nxt_wdata;
  logic                 nxt_we;
  logic                 nxt_re;
  logic                 nxt_done;
  logic [7:0]           nxt_rdata;

  assign ready = (state_ff == rcad_pkg::RCAD_PS_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_lat   = lat_ff;
    nxt_addr  = dev_addr_ff;
    nxt_wdata = dev_wdata_ff;
    nxt_we    = 1'b0;
    nxt_re    = 1'b0;
    nxt_done  = 1'b0;
    nxt_rdata = rdata_ff;
    case (state_ff)
      rcad_pkg::RCAD_PS_IDLE: begin
        if (req) begin
          nxt_addr  = req_addr;
          nxt_wdata = req_wr ? req_wdata : 8'h00;
          nxt_we    = req_wr;
          nxt_re    = ~req_wr;
          nxt_lat   = rcad_pkg::DEV_RD_LAT;
          nxt_state = req_wr ? rcad_pkg::RCAD_PS_DRIVE : rcad_pkg::RCAD_PS_LAT;
        end
      end
      rcad_pkg::RCAD_PS_DRIVE: begin
        nxt_done  = 1'b1;
        nxt_state = rcad_pkg::RCAD_PS_IDLE;
      end
      rcad_pkg::RCAD_PS_LAT: begin
        // sample once the read latency has passed
        if (lat_ff == 2'h0) begin
          nxt_rdata = dev_rdata;
          nxt_done  = 1'b1;
          nxt_state = rcad_pkg::RCAD_PS_IDLE;
        end else begin
          nxt_lat = lat_ff - 2'h1;
        end
      end
      default: nxt_state = rcad_pkg::RCAD_PS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= rcad_pkg::RCAD_PS_IDLE;
      lat_ff       <= 2'h0;
      dev_addr_ff  <= 8'h00;
      dev_wdata_ff <= 8'h00;
      dev_we_ff    <= 1'b0;
      dev_re_ff    <= 1'b0;
      done_ff      <= 1'b0;
      rdata_ff     <= 8'h00;
    end else begin
      state_ff     <= nxt_state;
      lat_ff       <= nxt_lat;
      dev_addr_ff  <= nxt_addr;
      dev_wdata_ff <= nxt_wdata;
      dev_we_ff    <= nxt_we;
      dev_re_ff    <= nxt_re;
      done_ff      <= nxt_done;
      rdata_ff     <= nxt_rdata;
    end
  end

endmodule

/* File: core/rcad_seq.sv */
`timescale 1ns/1ps
// Function
// [RULE1] two runs: reference then sensor, ratio
// [RULE2] select 32.768 kHz base clock first
// [RULE3] preload gate counter, clear count counter
// [RULE4] mode 01H: base gating, reference resistor
// [RULE5] control 01H starts run until overflow
// [RULE6] base counter overflow raises converter interrupt
// [RULE7] interrupt releases halt, run bit clears
// [RULE8] after base run, base counter holds zero
// [RULE9] second run preloads from first count
// [RULE10] mode 12H: oscillator gating, sensor resistor
// [RULE11] oscillator gating runs until its overflow
// [RULE12] oscillator overflow interrupts and stops run
// [RULE13] base counter then holds the result
// [RULE14] recommended order gives fixed second duration
// [RULE15] keep cpu halted during every run
// [RULE16] oscillator clock drivable onto monitor pin
// [RULE17] monitor output only for evaluation
// [RULE18] counting starts once synced run enable rises
// [RULE19] run enable starts oscillator and counting
// [RULE20] gating select bit picks gate counter
// [RULE21] counters 24 bits, overflow is carry out
module rcad_seq (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // device register port
  output logic [7:0]       dev_addr,
  output logic [7:0]       dev_wdata,
  output logic             dev_we,
  output logic             dev_re,
  input  wire logic [7:0]  dev_rdata,
  input  wire logic        converter_irq_signal
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // 1000000H minus a count, kept to the 24-bit counter width
  function automatic logic [23:0] preload_of(input logic [23:0] cnt);
    logic [24:0] diff;
    diff = rcad_pkg::CTR_SPAN - {1'b0, cnt};
    return diff[23:0];
  endfunction

  function automatic logic [7:0] byte_of(input logic [23:0] val, input logic [1:0] sel);
    logic [7:0] b;
    b = val[7:0];
    if (sel == 2'h1) begin
      b = val[15:8];
    end else if (sel == 2'h2) begin
      b = val[23:16];
    end
    return b;
  endfunction

  function automatic logic [7:0] ctr_base(input logic is_b);
    return is_b ? rcad_pkg::DEV_CB_ADDR : rcad_pkg::DEV_CA_ADDR;
  endfunction

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        order_ff;
  logic        nxt_order;
  logic        mon_ff;
  logic        nxt_mon;
  logic [23:0] gate_ff;
  logic [23:0] nxt_gate;
  logic        done_ff;
  logic        nxt_done;
  logic        bus_wr;
  logic        start_req;
  logic        finish;

  rcad_pkg::rcad_state_e state_ff;
  rcad_pkg::rcad_state_e nxt_state;
  logic        phase_ff;
  logic        nxt_phase;
  logic [3:0]  idx_ff;
  logic [3:0]  nxt_idx;
  logic        pend_ff;
  logic        nxt_pend;
  logic [23:0] acc_ff;
  logic [23:0] nxt_acc;
  logic [23:0] first_ff;
  logic [23:0] nxt_first;
  logic [23:0] result_ff;
  logic [23:0] nxt_result;
  logic        irq_d_ff;
  logic        nxt_irq_d;
  logic        busy;

  // one wait cycle per access; the answer stands at the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign bus_wr          = avs_write & ack_ff;
  assign busy            = (state_ff != rcad_pkg::RCAD_ST_IDLE);
  assign start_req       = bus_wr & (avs_address == rcad_pkg::SW_CTRL_OFS)
                           & avs_writedata[rcad_pkg::CTRL_START_BIT] & ~busy;

  always_comb begin
    nxt_ack   = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_order = order_ff;
    nxt_mon   = mon_ff;
    nxt_gate  = gate_ff;
    nxt_done  = done_ff;
    if (avs_read & ~ack_ff) begin
      case (avs_address)
        rcad_pkg::SW_CTRL_OFS:   nxt_rdata = {29'h0, mon_ff, order_ff, 1'b0};
        rcad_pkg::SW_GATE_OFS:   nxt_rdata = {8'h00, gate_ff};
        rcad_pkg::SW_STAT_OFS:   nxt_rdata = {29'h0, phase_ff, done_ff, busy};
        rcad_pkg::SW_FIRST_OFS:  nxt_rdata = {8'h00, first_ff};
        rcad_pkg::SW_RESULT_OFS: nxt_rdata = {8'h00, result_ff};
        default:                 nxt_rdata = 32'h0;
      endcase
    end
    // order and monitor frozen while busy
    if (bus_wr & ~busy & (avs_address == rcad_pkg::SW_CTRL_OFS)) begin
      nxt_order = avs_writedata[rcad_pkg::CTRL_ORDER_BIT];
      nxt_mon   = avs_writedata[rcad_pkg::CTRL_MON_BIT];
    end
    if (bus_wr & ~busy & (avs_address == rcad_pkg::SW_GATE_OFS)) begin
      nxt_gate = avs_writedata[23:0];
    end
    if (bus_wr & (avs_address == rcad_pkg::SW_STAT_OFS)
        & avs_writedata[rcad_pkg::STAT_DONE_BIT]) begin
      nxt_done = 1'b0;
    end
    if (start_req) begin
      nxt_done = 1'b0;
    end
    // completion wins over a clear in the same cycle
    if (finish) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
      order_ff <= 1'b0;
      mon_ff   <= 1'b0;
      gate_ff  <= rcad_pkg::GATE_RST;
      done_ff  <= 1'b0;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
      order_ff <= nxt_order;
      mon_ff   <= nxt_mon;
      gate_ff  <= nxt_gate;
      done_ff  <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // device access engine
  // ----------------------------------------------------------------
  logic       port_ready;
  logic       port_done;
  logic [7:0] port_rdata;
  logic       port_req;
  logic       port_wr;
  logic [7:0] port_addr;
  logic [7:0] port_wdata;

  rcad_dev_port u_port (
    .clk          (sys_clk),
    .rst_n        (rst_sync_ff),
    .req          (port_req),
    .req_wr       (port_wr),
    .req_addr     (port_addr),
    .req_wdata    (port_wdata),
    .ready        (port_ready),
    .done_ff      (port_done),
    .rdata_ff     (port_rdata),
    .dev_addr_ff  (dev_addr),
    .dev_wdata_ff (dev_wdata),
    .dev_we_ff    (dev_we),
    .dev_re_ff    (dev_re),
    .dev_rdata    (dev_rdata)
  );

  // ----------------------------------------------------------------
  // conversion sequence
  // ----------------------------------------------------------------
  logic        gate_is_b;
  logic [23:0] preload;
  logic [7:0]  mode_val;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [3:0]  last_idx;

  // gate counter swaps so the second gate is the first count
  assign gate_is_b = order_ff ^ phase_ff;                              // [RULE14] [RULE20]
  assign preload   = preload_of(phase_ff ? first_ff : gate_ff);        // [RULE3] [RULE9] [RULE21]
  assign mode_val  = (gate_is_b ? rcad_pkg::MODE_GATE_B : 8'h00)
                     | (phase_ff ? rcad_pkg::OM_SENSOR_CH0
                                 : rcad_pkg::OM_REF_CH0);              // [RULE4] [RULE10]
  assign last_idx  = phase_ff ? rcad_pkg::P1_LAST_IDX : rcad_pkg::P0_LAST_IDX;

  always_comb begin
    wr_addr = rcad_pkg::DEV_SBY_ADDR;
    wr_data = rcad_pkg::SBY_HALT;                                      // [RULE15]
    if (!phase_ff) begin
      case (idx_ff)
        4'h0: begin
          wr_addr = rcad_pkg::DEV_FREQ_ADDR;
          wr_data = rcad_pkg::FREQ_32K;                                // [RULE2]
        end
        4'h1: begin
          wr_addr = rcad_pkg::DEV_MON_ADDR;
          wr_data = {7'h00, mon_ff};                                   // [RULE16] [RULE17]
        end
        4'h2, 4'h3, 4'h4: begin
          wr_addr = ctr_base(gate_is_b) + {6'h00, idx_ff[1:0] - 2'h2};
          wr_data = byte_of(preload, idx_ff[1:0] - 2'h2);              // [RULE3]
        end
        4'h5, 4'h6, 4'h7: begin
          wr_addr = ctr_base(~gate_is_b) + {6'h00, idx_ff[1:0] - 2'h1};
          wr_data = rcad_pkg::ZERO_BYTE;                               // [RULE3]
        end
        4'h8: begin
          wr_addr = rcad_pkg::DEV_MODE_ADDR;
          wr_data = mode_val;
        end
        4'h9: begin
          wr_addr = rcad_pkg::DEV_CTRL_ADDR;
          wr_data = rcad_pkg::CTRL_RUN;                                // [RULE5]
        end
        default: begin
          wr_addr = rcad_pkg::DEV_SBY_ADDR;
          wr_data = rcad_pkg::SBY_HALT;
        end
      endcase
    end else begin
      // the first gate counter is already zero after overflow
      case (idx_ff)
        4'h0, 4'h1, 4'h2: begin
          wr_addr = ctr_base(gate_is_b) + {6'h00, idx_ff[1:0]};
          wr_data = byte_of(preload, idx_ff[1:0]);                     // [RULE9] [RULE8]
        end
        4'h3: begin
          wr_addr = rcad_pkg::DEV_MODE_ADDR;
          wr_data = mode_val;
        end
        4'h4: begin
          wr_addr = rcad_pkg::DEV_CTRL_ADDR;
          wr_data = rcad_pkg::CTRL_RUN;                                // [RULE5]
        end
        default: begin
          wr_addr = rcad_pkg::DEV_SBY_ADDR;
          wr_data = rcad_pkg::SBY_HALT;
        end
      endcase
    end
  end

  always_comb begin
    port_req   = 1'b0;
    port_wr    = 1'b0;
    port_addr  = wr_addr;
    port_wdata = wr_data;
    if ((state_ff == rcad_pkg::RCAD_ST_WRITE) & ~pend_ff) begin
      port_req = 1'b1;
      port_wr  = 1'b1;
    end else if ((state_ff == rcad_pkg::RCAD_ST_READ) & ~pend_ff) begin
      port_req  = 1'b1;
      port_addr = ctr_base(~gate_is_b) + {6'h00, idx_ff[1:0]};
    end
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_phase  = phase_ff;
    nxt_idx    = idx_ff;
    nxt_pend   = pend_ff;
    nxt_acc    = acc_ff;
    nxt_first  = first_ff;
    nxt_result = result_ff;
    nxt_irq_d  = converter_irq_signal;
    finish     = 1'b0;
    if (port_req & port_ready) begin
      nxt_pend = 1'b1;
    end
    case (state_ff)
      rcad_pkg::RCAD_ST_IDLE: begin
        if (start_req) begin
          nxt_state = rcad_pkg::RCAD_ST_WRITE;                         // [RULE1]
          nxt_phase = 1'b0;
          nxt_idx   = 4'h0;
        end
      end
      rcad_pkg::RCAD_ST_WRITE: begin
        if (port_done) begin
          nxt_pend = 1'b0;
          nxt_idx  = idx_ff + 4'h1;
          if (idx_ff == last_idx) begin
            nxt_idx   = 4'h0;
            nxt_state = rcad_pkg::RCAD_ST_WAIT;
          end
        end
      end
      rcad_pkg::RCAD_ST_WAIT: begin
        // device stops the run on overflow and interrupts
        if (converter_irq_signal & ~irq_d_ff) begin
          nxt_state = rcad_pkg::RCAD_ST_READ;                          // [RULE6] [RULE7] [RULE11] [RULE12]
        end
      end
      rcad_pkg::RCAD_ST_READ: begin
        if (port_done) begin
          nxt_pend = 1'b0;
          nxt_idx  = idx_ff + 4'h1;
          case (idx_ff[1:0])
            2'h0:    nxt_acc = {acc_ff[23:8], port_rdata};
            2'h1:    nxt_acc = {acc_ff[23:16], port_rdata, acc_ff[7:0]};
            default: nxt_acc = {port_rdata, acc_ff[15:0]};
          endcase
          if (idx_ff[1:0] == rcad_pkg::CTR_LAST_BYTE) begin
            nxt_idx = 4'h0;
            if (!phase_ff) begin
              nxt_first = {port_rdata, acc_ff[15:0]};
              nxt_phase = 1'b1;
              nxt_state = rcad_pkg::RCAD_ST_WRITE;
            end else begin
              nxt_result = {port_rdata, acc_ff[15:0]};                 // [RULE13] [RULE1]
              nxt_phase  = 1'b0;
              nxt_state  = rcad_pkg::RCAD_ST_IDLE;
              finish     = 1'b1;
            end
          end
        end
      end
      default: nxt_state = rcad_pkg::RCAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff  <= rcad_pkg::RCAD_ST_IDLE;
      phase_ff  <= 1'b0;
      idx_ff    <= 4'h0;
      pend_ff   <= 1'b0;
      acc_ff    <= 24'h0;
      first_ff  <= 24'h0;
      result_ff <= 24'h0;
      irq_d_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      idx_ff    <= nxt_idx;
      pend_ff   <= nxt_pend;
      acc_ff    <= nxt_acc;
      first_ff  <= nxt_first;
      result_ff <= nxt_result;
      irq_d_ff  <= nxt_irq_d;
    end
  end

  // run enable resync and counting stay in the device [RULE18] [RULE19]

endmodule

/* File: testbench/rcad_dev_model.sv */
`timescale 1ns/1ps
module rcad_dev_model #(
  parameter int BS_DIV   = 4,
  parameter int RREF_DIV = 3,
  parameter int RSEN_DIV = 5
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register pins
  input  wire logic [7:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_we,
  input  wire logic       dev_re,
  output logic [7:0]      dev_rdata,
  output logic            converter_irq_signal
);
  logic [7:0]  freq_ff, mon_ff, mode_ff, rd_ff;
  logic [23:0] ca_ff, cb_ff, ca_n, cb_n;
  logic        run_ff, en_ff, halt_ff, rdv_ff, ca_c, cb_c, tk_a, tk_b, ovf;
  logic [1:0]  irq_ff;
  int          pa_ff, pb_ff, bdiv, rdiv;

  // wrong freq select slows base clock
  assign bdiv = (freq_ff == 8'h00) ? BS_DIV : 2 * BS_DIV;
  assign rdiv = (mode_ff[3:0] == 4'h1) ? RREF_DIV : (mode_ff[3:0] == 4'h2) ? RSEN_DIV : 0;
  assign converter_irq_signal = (irq_ff != 2'h0);
  assign dev_rdata = rd_ff;

  always_comb begin
    tk_a = en_ff && (pa_ff + 1 == bdiv);
    tk_b = en_ff && (rdiv != 0) && (pb_ff + 1 == rdiv);
    {ca_c, ca_n} = {1'b0, ca_ff} + 25'(tk_a);
    {cb_c, cb_n} = {1'b0, cb_ff} + 25'(tk_b);
    ovf = mode_ff[4] ? cb_c : ca_c;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {freq_ff, mon_ff, mode_ff, rd_ff, ca_ff, cb_ff, run_ff, en_ff, halt_ff, rdv_ff, irq_ff} <= '0;
      pa_ff <= 0;
      pb_ff <= 0;
    end else begin
      rdv_ff <= dev_re;
      if (dev_re) begin
        rd_ff <= dev_addr[4] ? 8'((dev_addr[2] ? cb_ff : ca_ff) >> (8 * dev_addr[1:0])) : 8'h00;
      end else if (rdv_ff) begin
        rd_ff <= ~rd_ff; // stale byte turns to its inverse
      end
      if (irq_ff != 2'h0) irq_ff <= irq_ff - 2'h1;
      en_ff <= run_ff;
      pa_ff <= (en_ff && !tk_a) ? pa_ff + 1 : 0;
      pb_ff <= (en_ff && !tk_b) ? pb_ff + 1 : 0;
      if (en_ff) begin
        ca_ff <= ca_n;
        cb_ff <= cb_n;
      end
      if (dev_we) begin
        case (dev_addr)
          8'h00: freq_ff <= dev_wdata;
          8'h01: mon_ff <= dev_wdata;
          8'h10, 8'h11, 8'h12: ca_ff[8 * dev_addr[1:0] +: 8] <= dev_wdata;
          8'h14, 8'h15, 8'h16: cb_ff[8 * dev_addr[1:0] +: 8] <= dev_wdata;
          8'h18: mode_ff <= dev_wdata;
          8'h19: run_ff <= dev_wdata[0];
          8'h1a: halt_ff <= dev_wdata[0];
          default: ;
        endcase
      end
      if (ovf) begin
        run_ff <= 1'b0;
        en_ff <= 1'b0;
        halt_ff <= 1'b0;
        irq_ff <= 2'h3;
      end
    end
  end
endmodule

/* File: testbench/rcad_seq_props.sv */
`timescale 1ns/1ps
module rcad_seq_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // avalon-mm slave
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // device register port
  input wire logic [7:0]  dev_addr,
  input wire logic [7:0]  dev_wdata,
  input wire logic        dev_we,
  input wire logic        dev_re,
  input wire logic [7:0]  dev_rdata,
  input wire logic        converter_irq_signal
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_freq_val;
    dev_we && dev_addr == rcad_pkg::DEV_FREQ_ADDR |-> dev_wdata == rcad_pkg::FREQ_32K;
  endproperty
  a_freq_val: assert property (p_freq_val) else $error("bad freq");
  property p_ctrl_val;
    dev_we && dev_addr == rcad_pkg::DEV_CTRL_ADDR |-> dev_wdata == rcad_pkg::CTRL_RUN;
  endproperty
  a_ctrl_val: assert property (p_ctrl_val) else $error("bad control");
  property p_mode_val;
    dev_we && dev_addr == rcad_pkg::DEV_MODE_ADDR |-> dev_wdata inside {8'h01, 8'h12, 8'h11, 8'h02};
  endproperty
  a_mode_val: assert property (p_mode_val) else $error("bad mode");
  property p_halt_val;
    dev_we && dev_addr == rcad_pkg::DEV_SBY_ADDR |-> dev_wdata == rcad_pkg::SBY_HALT;
  endproperty
  a_halt_val: assert property (p_halt_val) else $error("bad halt");
  property p_we_pulse;
    dev_we |=> !dev_we && !dev_re;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write too close");
  property p_re_space;
    dev_re |=> !dev_re [*2];
  endproperty
  a_re_space: assert property (p_re_space) else $error("read too close");
  property p_re_addr;
    dev_re |-> dev_addr[7:3] == 5'h02 && dev_addr[1:0] != 2'h3;
  endproperty
  a_re_addr: assert property (p_re_addr) else $error("read off counters");
  property p_irq_read;
    $rose(converter_irq_signal) |-> ##[1:40] dev_re;
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("no read after irq");
  property p_av_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_av_wait: assert property (p_av_wait) else $error("bad wait");
  property p_unmapped;
    avs_read && !avs_waitrequest && (avs_address[1:0] != 2'h0 || avs_address > 5'h10)
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
endmodule

bind rcad_seq rcad_seq_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata),
  .converter_irq_signal(converter_irq_signal)
);

/* File: testbench/rcad_seq_tb_top.sv */
`timescale 1ns/1ps
module rcad_seq_tb_top;
  localparam int BS = 4, RR = 3, RS = 5;
  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0]  dev_addr, dev_wdata, dev_rdata;
  logic        dev_we, dev_re, converter_irq_signal;
  int          fail_count, num_checks;
  integer      seed;

  rcad_seq uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata),
    .converter_irq_signal(converter_irq_signal));
  rcad_dev_model #(.BS_DIV(BS), .RREF_DIV(RR), .RSEN_DIV(RS)) dev (
    .clk(sys_clk), .rst_n(rst_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata),
    .converter_irq_signal(converter_irq_signal));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // held until a rising edge samples waitrequest low
  task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, wd, wr, !wr};
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) fail_count++;
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask

  function automatic logic [23:0] cnt(input int n, input int num, input int den);
    return 24'((n * num) / den);
  endfunction

  task automatic run_conv(input logic ord, input logic [23:0] g, input logic mon);
    logic [31:0] d;
    logic [23:0] f, r;
    int n;
    f = ord ? cnt(g, RR, BS) : cnt(g, BS, RR);
    r = ord ? cnt(f, BS, RS) : cnt(f, RS, BS);
    av_xfer(1'b1, rcad_pkg::SW_GATE_OFS, {8'h00, g}, d);
    av_xfer(1'b1, rcad_pkg::SW_CTRL_OFS, {29'h0, mon, ord, 1'b1}, d);
    av_xfer(1'b1, rcad_pkg::SW_GATE_OFS, {8'h00, ~g}, d);
    av_xfer(1'b0, rcad_pkg::SW_GATE_OFS, 32'h0, d);
    chk(d, {8'h00, g});
    n = 0;
    do begin
      av_xfer(1'b0, rcad_pkg::SW_STAT_OFS, 32'h0, d);
      n++;
    end while (d[rcad_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 6000);
    chk({30'h0, d[1:0]}, 32'h2);
    av_xfer(1'b0, rcad_pkg::SW_FIRST_OFS, 32'h0, d);
    chk(d, {8'h00, f});
    av_xfer(1'b0, rcad_pkg::SW_RESULT_OFS, 32'h0, d);
    chk(d, {8'h00, r});
    chk({31'h0, dev.halt_ff}, 32'h0);
    chk({24'h0, dev.mon_ff}, {31'h0, mon});
    chk({24'h0, dev.freq_ff}, 32'h0);
    chk({24'h0, dev.mode_ff}, ord ? 32'h02 : 32'h12);
    av_xfer(1'b0, rcad_pkg::SW_CTRL_OFS, 32'h0, d);
    chk(d, {29'h0, mon, ord, 1'b0});
    av_xfer(1'b1, rcad_pkg::SW_STAT_OFS, 32'h2, d);
    av_xfer(1'b0, rcad_pkg::SW_STAT_OFS, 32'h0, d);
    chk(d, 32'h0);
    $display("conversion done %0d %h", ord, g);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    seed = 10;
    {fail_count, num_checks} = '0;
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    av_xfer(1'b1, 5'h1c, $random(seed), d);
    for (int i = 0; i < 8; i++) begin
      av_xfer(1'b0, 5'(4 * i), 32'h0, d);
      chk(d, (i == 1) ? {8'h00, rcad_pkg::GATE_RST} : 32'h0);
    end
    $display("reset test done");
    run_conv(1'b0, rcad_pkg::GATE_RST, 1'b1);
    run_conv(1'b1, 24'h000064, 1'b0);
    repeat (4) run_conv($random(seed) & 1, 24'(100 + ($random(seed) & 255)), $random(seed) & 1);
    end_of_test;
  end

  initial begin
    #300000;
    fail_count++;
    end_of_test;
  end
endmodule
